// File: rtl/sbt_params.svh
// numeric constants of the sixteen-bit timer core: register indices,
// field positions, reset values and prescaler masks
// assumes the including file also uses sbt_pkg for the types
`ifndef SBT_PARAMS_SVH
`define SBT_PARAMS_SVH

// ------------------------------------------------------------------
// register indices; the apb byte address is four times the index
// ------------------------------------------------------------------
`define SBT_IDX_COUNT_LO   8'hE2
`define SBT_IDX_COUNT_SNAP 8'hE3
`define SBT_IDX_CTL        8'hE4
`define SBT_IDX_CCTL0      8'hE5
`define SBT_IDX_CC0_LO     8'hDA
`define SBT_IDX_CC0_HI     8'hDB
`define SBT_IDX_RADIO_MASK 8'hF0
`define SBT_IDX_OVF_MASK   8'hF1
`define SBT_MIN_AW         10

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define SBT_CTL_FLG_HI     7
`define SBT_CTL_FLG_LO     4
`define SBT_CTL_PSC_HI     3
`define SBT_CTL_PSC_LO     2
`define SBT_CTL_MODE_HI    1
`define SBT_CTL_MODE_LO    0
`define SBT_CC_SRC         7
`define SBT_CC_MASK        6
`define SBT_CC_ACT_HI      5
`define SBT_CC_ACT_LO      3
`define SBT_CC_FSEL        2
`define SBT_CC_EDGE_HI     1
`define SBT_CC_EDGE_LO     0

// ------------------------------------------------------------------
// reset values, terminal count and prescaler masks
// ------------------------------------------------------------------
`define SBT_COUNT_RST      16'h0000
`define SBT_COUNT_TERM     16'hFFFF
`define SBT_BYTE_RST       8'h00
`define SBT_MASK_RST       1'h1
`define SBT_DIV8_M         7'h07
`define SBT_DIV32_M        7'h1F
`define SBT_DIV128_M       7'h7F

`endif

// File: rtl/sbt_pkg.sv
// types of the sixteen-bit timer core
// assumes sbt_params.svh holds the numeric constants
package sbt_pkg;

	typedef enum logic [1:0] {
		SBT_SUSPEND = 2'h0,
		SBT_FREE    = 2'h1,
		SBT_MODULO  = 2'h2,
		SBT_UPDOWN  = 2'h3
	} sbt_mode_t;

	typedef enum logic [2:0] {
		SBT_ACT_SET    = 3'h0,
		SBT_ACT_CLR    = 3'h1,
		SBT_ACT_TOG    = 3'h2,
		SBT_ACT_SET_UP = 3'h3,
		SBT_ACT_CLR_UP = 3'h4
	} sbt_action_t;

	typedef enum logic {
		SBT_UP   = 1'h0,
		SBT_DOWN = 1'h1
	} sbt_dir_t;

	typedef enum logic [3:0] {
		SBT_R_NONE, SBT_R_LOW, SBT_R_SNAP, SBT_R_CTL, SBT_R_CCTL,
		SBT_R_CCL, SBT_R_CCH, SBT_R_RADIO, SBT_R_OVM
	} sbt_reg_t;

	typedef struct packed {
		logic [15:0] count_value;
		logic [7:0]  counter_high_snapshot;
		logic [15:0] channel0_compare_value;
		logic [3:0]  pending_flags; // ch2, ch1, ch0, overflow
		logic [1:0]  psc_sel;
		sbt_mode_t   mode;
		logic        capture_source_select;
		logic        channel_irq_mask;
		sbt_action_t compare_action;
		logic        compare_sel;
		logic [1:0]  capture_edge_select;
		logic [7:0]  radio_event_mask;
		logic        ovf_irq_mask;
		sbt_dir_t    dir;
		logic [6:0]  psc;
		logic [2:0]  pin_sync;
		logic        pin_lvl;
		logic        ch0_out;
		logic        irq;
		logic [31:0] prdata;
		logic        pslverr;
	} sbt_state_t;

endpackage

// File: rtl/sbt_timer.sv
// sixteen-bit timer core with prescaler, overflow and channel flags and
// channel 0 capture/compare, reached as byte registers over apb
// assumes tick, radio events and channel 1/2 events share clock;
// capture_pin is asynchronous and is synchronised here
`timescale 1ns/1ps
`include "sbt_params.svh"

// What this block does
// [RL1] low byte read gives live low, snaps high
// [RL2] high byte reads last snapshot only
// [RL3] low byte write with pstrb[0] set zeroes count
// [RL4] three channel flags at 7..5, write-0 clear
// [RL5] overflow flag at bit 4 on terminal/turn
// [RL6] prescaler divides tick by 1/8/32/128
// [RL7] prescaler counter never reset by writes
// [RL8] mode 00 holds count
// [RL9] mode 01 counts 0 to FFFF, wraps
// [RL10] mode 10 counts 0 to compare, restarts
// [RL11] mode 11 counts up to compare, down
// [RL12] capture source pin or masked radio events
// [RL13] actions set, clear, toggle on match
// [RL14] 011 set on up match, clear later
// [RL15] 100 clear on up match, set later
// [RL16] function bit chooses capture or compare
// [RL17] capture edge none, rise, fall, both
// [RL18] channel 0 mask resets to one
// [RL19] software avoids action codes 101..111
// [RL20] flags set unmasked; irq flag masked
// [RL21] up/down compare: turn sets both flags
module sbt_timer #(
	parameter int ADDR_W = 12
) (
	input  logic              clock,
	input  logic              resetn,
	input  logic              psel,
	input  logic              penable,
	input  logic              pwrite,
	input  logic [ADDR_W-1:0] paddr,
	input  logic [31:0]       pwdata,
	input  logic [3:0]        pstrb,
	output logic              pready,
	output logic [31:0]       prdata,
	output logic              pslverr,
	input  logic              tick,
	input  logic              capture_pin,
	input  logic [7:0]        radio_events,
	input  logic              ch1_event,
	input  logic              ch2_event,
	input  logic              ch1_irq_mask,
	input  logic              ch2_irq_mask,
	output logic [15:0]       count_value,
	output logic              ch0_out,
	output logic              cpu_timer_irq_flag
);

	// ------------------------------------------------------------------
	// elaboration check
	// ------------------------------------------------------------------
	// the highest index needs ten address bits
	if (ADDR_W < `SBT_MIN_AW)
	begin : g_bad_aw
		$error("sbt_timer: ADDR_W below ten bits");
	end

	// ------------------------------------------------------------------
	// functions
	// ------------------------------------------------------------------
	// word-aligned index decode, shared by read and write paths
	function automatic sbt_pkg::sbt_reg_t sbt_decode(
		input logic [ADDR_W-1:0] addr
	);
		logic [ADDR_W-3:0] idx;
		idx = addr[ADDR_W-1:2];
		if (addr[1:0] != 2'h0)
			sbt_decode = sbt_pkg::SBT_R_NONE;
		else if (idx == (ADDR_W-2)'(`SBT_IDX_COUNT_LO))
			sbt_decode = sbt_pkg::SBT_R_LOW;
		else if (idx == (ADDR_W-2)'(`SBT_IDX_COUNT_SNAP))
			sbt_decode = sbt_pkg::SBT_R_SNAP;
		else if (idx == (ADDR_W-2)'(`SBT_IDX_CTL))
			sbt_decode = sbt_pkg::SBT_R_CTL;
		else if (idx == (ADDR_W-2)'(`SBT_IDX_CCTL0))
			sbt_decode = sbt_pkg::SBT_R_CCTL;
		else if (idx == (ADDR_W-2)'(`SBT_IDX_CC0_LO))
			sbt_decode = sbt_pkg::SBT_R_CCL;
		else if (idx == (ADDR_W-2)'(`SBT_IDX_CC0_HI))
			sbt_decode = sbt_pkg::SBT_R_CCH;
		else if (idx == (ADDR_W-2)'(`SBT_IDX_RADIO_MASK))
			sbt_decode = sbt_pkg::SBT_R_RADIO;
		else if (idx == (ADDR_W-2)'(`SBT_IDX_OVF_MASK))
			sbt_decode = sbt_pkg::SBT_R_OVM;
		else
			sbt_decode = sbt_pkg::SBT_R_NONE;
	endfunction

	// prescaler terminal detect for the selected division
	function automatic logic sbt_fire(
		input logic [1:0] sel,
		input logic [6:0] psc
	);
		case (sel)
			2'h0:    sbt_fire = 1'h1;
			2'h1:    sbt_fire = (psc & `SBT_DIV8_M) == `SBT_DIV8_M;
			2'h2:    sbt_fire = (psc & `SBT_DIV32_M) == `SBT_DIV32_M;
			default: sbt_fire = psc == `SBT_DIV128_M;
		endcase
	endfunction

	// ------------------------------------------------------------------
	// state and helpers
	// ------------------------------------------------------------------
	sbt_pkg::sbt_state_t st_ff;
	sbt_pkg::sbt_state_t nxt_st;
	sbt_pkg::sbt_reg_t   sel;
	logic                setup;
	logic                we;
	logic                fire;
	logic                upd;
	logic [15:0]         step;
	logic                wrap_ev;
	logic                turn_ev;
	logic                zero_ev;
	logic                match_ev;
	logic                m_up;
	logic                m_dn;
	logic                rise;
	logic                fall;
	logic                capt_ev;
	logic                ch0_set;
	logic [3:0]          clr_mask;
	logic [7:0]          rd;

	// ------------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------------
	always_comb
	begin
		nxt_st   = st_ff;
		sel      = sbt_decode(paddr);
		setup    = psel & ~penable;
		we       = psel & penable & pwrite & pstrb[0];
		wrap_ev  = 1'h0;
		turn_ev  = 1'h0;
		clr_mask = 4'h0;
		rd       = `SBT_BYTE_RST;

		// free-running prescaler; writes never touch it
		if (tick)
			nxt_st.psc = 7'(st_ff.psc + 7'h01); // [RL7]
		fire = tick & sbt_fire(st_ff.psc_sel, st_ff.psc); // [RL6]
		upd  = fire & (st_ff.mode != sbt_pkg::SBT_SUSPEND); // [RL8]

		// counting step per mode
		step = st_ff.count_value;
		if (upd)
		begin
			case (st_ff.mode)
				sbt_pkg::SBT_FREE:
				begin
					step    = 16'(st_ff.count_value + 16'h0001); // [RL9]
					wrap_ev = st_ff.count_value == `SBT_COUNT_TERM; // [RL5]
				end
				sbt_pkg::SBT_MODULO:
				begin
					// >= so a lowered compare value cannot strand the count
					if (st_ff.count_value >= st_ff.channel0_compare_value)
					begin
						step    = `SBT_COUNT_RST; // [RL10]
						wrap_ev = 1'h1; // [RL5]
					end
					else
						step = 16'(st_ff.count_value + 16'h0001);
				end
				sbt_pkg::SBT_UPDOWN:
				begin
					if (st_ff.dir == sbt_pkg::SBT_DOWN)
					begin
						if (st_ff.count_value <= 16'h0001)
						begin
							step        = `SBT_COUNT_RST; // [RL11]
							turn_ev     = 1'h1; // [RL5]
							nxt_st.dir  = sbt_pkg::SBT_UP;
						end
						else
							step = 16'(st_ff.count_value - 16'h0001);
					end
					else if (st_ff.count_value >=
						st_ff.channel0_compare_value)
					begin
						nxt_st.dir = sbt_pkg::SBT_DOWN; // [RL11]
						if (st_ff.count_value != `SBT_COUNT_RST)
							step = 16'(st_ff.count_value - 16'h0001);
					end
					else
						step = 16'(st_ff.count_value + 16'h0001);
				end
				default: step = st_ff.count_value;
			endcase
		end
		nxt_st.count_value = step;

		// compare events of channel 0
		match_ev = upd & st_ff.compare_sel & // [RL16]
			(step == st_ff.channel0_compare_value);
		m_up     = match_ev & (st_ff.dir == sbt_pkg::SBT_UP);
		m_dn     = match_ev & (st_ff.dir == sbt_pkg::SBT_DOWN);
		zero_ev  = upd & (step == `SBT_COUNT_RST) &
			(st_ff.count_value != `SBT_COUNT_RST);

		// output action; reserved codes leave the output alone
		case (st_ff.compare_action)
			sbt_pkg::SBT_ACT_SET:
				if (match_ev)
					nxt_st.ch0_out = 1'h1; // [RL13]
			sbt_pkg::SBT_ACT_CLR:
				if (match_ev)
					nxt_st.ch0_out = 1'h0; // [RL13]
			sbt_pkg::SBT_ACT_TOG:
				if (match_ev)
					nxt_st.ch0_out = ~st_ff.ch0_out; // [RL13]
			sbt_pkg::SBT_ACT_SET_UP:
				if (m_up)
					nxt_st.ch0_out = 1'h1; // [RL14]
				else if (st_ff.mode == sbt_pkg::SBT_UPDOWN ? m_dn : zero_ev)
					nxt_st.ch0_out = 1'h0; // [RL14]
			sbt_pkg::SBT_ACT_CLR_UP:
				if (m_up)
					nxt_st.ch0_out = 1'h0; // [RL15]
				else if (st_ff.mode == sbt_pkg::SBT_UPDOWN ? m_dn : zero_ev)
					nxt_st.ch0_out = 1'h1; // [RL15]
			default: nxt_st.ch0_out = st_ff.ch0_out;
		endcase

		// capture pin: three stages, level moves when 2nd and 3rd agree
		nxt_st.pin_sync = {st_ff.pin_sync[1:0], capture_pin};
		if (st_ff.pin_sync[1] == st_ff.pin_sync[2])
			nxt_st.pin_lvl = st_ff.pin_sync[2];
		rise = (st_ff.pin_sync[1] == st_ff.pin_sync[2]) &
			st_ff.pin_sync[2] & ~st_ff.pin_lvl;
		fall = (st_ff.pin_sync[1] == st_ff.pin_sync[2]) &
			~st_ff.pin_sync[2] & st_ff.pin_lvl;
		capt_ev = ~st_ff.compare_sel & // [RL16]
			(st_ff.capture_edge_select != 2'h0) & // [RL17]
			(st_ff.capture_source_select ? // [RL12]
			|(radio_events & st_ff.radio_event_mask) :
			((rise & st_ff.capture_edge_select[0]) | // [RL17]
			(fall & st_ff.capture_edge_select[1])));

		// channel 0 flag source depends on mode and function
		if (~st_ff.compare_sel)
			ch0_set = capt_ev;
		else if (st_ff.mode == sbt_pkg::SBT_UPDOWN)
			ch0_set = turn_ev; // [RL21]
		else
			ch0_set = match_ev;

		// register writes, taken at the access edge
		if (we)
		begin
			if (sel == sbt_pkg::SBT_R_LOW)
			begin
				nxt_st.count_value = `SBT_COUNT_RST; // [RL3]
				nxt_st.dir         = sbt_pkg::SBT_UP;
			end
			else if (sel == sbt_pkg::SBT_R_CTL)
			begin
				clr_mask = ~pwdata[`SBT_CTL_FLG_HI:`SBT_CTL_FLG_LO]; // [RL4]
				nxt_st.psc_sel = pwdata[`SBT_CTL_PSC_HI:`SBT_CTL_PSC_LO];
				nxt_st.mode    = sbt_pkg::sbt_mode_t'(
					pwdata[`SBT_CTL_MODE_HI:`SBT_CTL_MODE_LO]);
			end
			else if (sel == sbt_pkg::SBT_R_CCTL)
			begin
				nxt_st.capture_source_select = pwdata[`SBT_CC_SRC];
				nxt_st.channel_irq_mask      = pwdata[`SBT_CC_MASK];
				nxt_st.compare_action        = sbt_pkg::sbt_action_t'(
					pwdata[`SBT_CC_ACT_HI:`SBT_CC_ACT_LO]);
				nxt_st.compare_sel           = pwdata[`SBT_CC_FSEL];
				nxt_st.capture_edge_select   =
					pwdata[`SBT_CC_EDGE_HI:`SBT_CC_EDGE_LO];
			end
			else if (sel == sbt_pkg::SBT_R_CCL)
				nxt_st.channel0_compare_value[7:0] = pwdata[7:0];
			else if (sel == sbt_pkg::SBT_R_CCH)
				nxt_st.channel0_compare_value[15:8] = pwdata[7:0];
			else if (sel == sbt_pkg::SBT_R_RADIO)
				nxt_st.radio_event_mask = pwdata[7:0];
			else if (sel == sbt_pkg::SBT_R_OVM)
				nxt_st.ovf_irq_mask = pwdata[0];
		end

		// a capture outranks a software write of the value
		if (capt_ev)
			nxt_st.channel0_compare_value = st_ff.count_value; // [RL12]

		// flags: events set regardless of masks, and set beats clear
		nxt_st.pending_flags = (st_ff.pending_flags & ~clr_mask) | // [RL4]
			{ch2_event, ch1_event, ch0_set, wrap_ev | turn_ev}; // [RL20]

		// cpu flag only through the mask bits
		nxt_st.irq = |(st_ff.pending_flags & {ch2_irq_mask, ch1_irq_mask,
			st_ff.channel_irq_mask, st_ff.ovf_irq_mask}); // [RL20]

		// read mux
		if (sel == sbt_pkg::SBT_R_LOW)
			rd = st_ff.count_value[7:0]; // [RL1]
		else if (sel == sbt_pkg::SBT_R_SNAP)
			rd = st_ff.counter_high_snapshot; // [RL2]
		else if (sel == sbt_pkg::SBT_R_CTL)
		begin
			rd[`SBT_CTL_FLG_HI:`SBT_CTL_FLG_LO]   = st_ff.pending_flags;
			rd[`SBT_CTL_PSC_HI:`SBT_CTL_PSC_LO]   = st_ff.psc_sel;
			rd[`SBT_CTL_MODE_HI:`SBT_CTL_MODE_LO] = st_ff.mode;
		end
		else if (sel == sbt_pkg::SBT_R_CCTL)
		begin
			rd[`SBT_CC_SRC]                    = st_ff.capture_source_select;
			rd[`SBT_CC_MASK]                   = st_ff.channel_irq_mask;
			rd[`SBT_CC_ACT_HI:`SBT_CC_ACT_LO]  = st_ff.compare_action;
			rd[`SBT_CC_FSEL]                   = st_ff.compare_sel;
			rd[`SBT_CC_EDGE_HI:`SBT_CC_EDGE_LO] = st_ff.capture_edge_select;
		end
		else if (sel == sbt_pkg::SBT_R_CCL)
			rd = st_ff.channel0_compare_value[7:0];
		else if (sel == sbt_pkg::SBT_R_CCH)
			rd = st_ff.channel0_compare_value[15:8];
		else if (sel == sbt_pkg::SBT_R_RADIO)
			rd = st_ff.radio_event_mask;
		else if (sel == sbt_pkg::SBT_R_OVM)
			rd = {7'h00, st_ff.ovf_irq_mask};

		// answer is prepared in setup so access needs no wait state
		if (setup)
		begin
			nxt_st.prdata  = pwrite ? 32'h0000_0000 : {24'h00_0000, rd};
			nxt_st.pslverr = sel == sbt_pkg::SBT_R_NONE;
			if (~pwrite && sel == sbt_pkg::SBT_R_LOW)
				nxt_st.counter_high_snapshot =
					st_ff.count_value[15:8]; // [RL1]
		end
	end

	// ------------------------------------------------------------------
	// state register
	// ------------------------------------------------------------------
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			st_ff.count_value            <= `SBT_COUNT_RST;
			st_ff.counter_high_snapshot  <= `SBT_BYTE_RST;
			st_ff.channel0_compare_value <= `SBT_COUNT_RST;
			st_ff.pending_flags          <= 4'h0;
			st_ff.psc_sel                <= 2'h0;
			st_ff.mode                   <= sbt_pkg::SBT_SUSPEND;
			st_ff.capture_source_select  <= 1'h0;
			st_ff.channel_irq_mask       <= `SBT_MASK_RST; // [RL18]
			st_ff.compare_action         <= sbt_pkg::SBT_ACT_SET;
			st_ff.compare_sel            <= 1'h0;
			st_ff.capture_edge_select    <= 2'h0;
			st_ff.radio_event_mask       <= `SBT_BYTE_RST;
			st_ff.ovf_irq_mask           <= `SBT_MASK_RST;
			st_ff.dir                    <= sbt_pkg::SBT_UP;
			st_ff.psc                    <= 7'h00;
			st_ff.pin_sync               <= 3'h0;
			st_ff.pin_lvl                <= 1'h0;
			st_ff.ch0_out                <= 1'h0;
			st_ff.irq                    <= 1'h0;
			st_ff.prdata                 <= 32'h0000_0000;
			st_ff.pslverr                <= 1'h0;
		end
		else
			st_ff <= nxt_st;
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	// zero wait states: the answer is ready on entering access
	assign pready             = 1'h1;
	assign prdata             = st_ff.prdata;
	assign pslverr            = st_ff.pslverr;
	assign count_value        = st_ff.count_value;
	assign ch0_out            = st_ff.ch0_out;
	assign cpu_timer_irq_flag = st_ff.irq;

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);

	sequence s_low_read;
		setup && !pwrite && sel == sbt_pkg::SBT_R_LOW;
	endsequence

	property p_low_read;
		s_low_read |=> prdata[7:0] == $past(st_ff.count_value[7:0]) &&
			st_ff.counter_high_snapshot == $past(st_ff.count_value[15:8]);
	endproperty
	a_low_read: assert property (p_low_read) // [RL1]
		else $error("low read or snapshot wrong");

	property p_snap_hold;
		!(setup && !pwrite && sel == sbt_pkg::SBT_R_LOW) |=>
			$stable(st_ff.counter_high_snapshot);
	endproperty
	a_snap_hold: assert property (p_snap_hold) // [RL2]
		else $error("snapshot moved without low read");

	property p_clear;
		we && sel == sbt_pkg::SBT_R_LOW |=> count_value == `SBT_COUNT_RST;
	endproperty
	a_clear: assert property (p_clear) // [RL3]
		else $error("low byte write did not clear count");

	property p_flag_keep;
		we && sel == sbt_pkg::SBT_R_CTL && pwdata[7:5] == 3'h7 |=>
			(st_ff.pending_flags[3:1] & $past(st_ff.pending_flags[3:1]))
			== $past(st_ff.pending_flags[3:1]);
	endproperty
	a_flag_keep: assert property (p_flag_keep) // [RL4]
		else $error("writing one cleared a flag");

	property p_flag_clr;
		we && sel == sbt_pkg::SBT_R_CTL && !pwdata[6] && !ch1_event |=>
			!st_ff.pending_flags[2];
	endproperty
	a_flag_clr: assert property (p_flag_clr) // [RL4]
		else $error("writing zero left channel 1 flag set");

	property p_free_wrap;
		upd && st_ff.mode == sbt_pkg::SBT_FREE &&
			count_value == `SBT_COUNT_TERM && !we |=>
			count_value == `SBT_COUNT_RST && st_ff.pending_flags[0];
	endproperty
	a_free_wrap: assert property (p_free_wrap) // [RL9]
		else $error("free-running wrap or overflow flag wrong");

	property p_modulo;
		upd && st_ff.mode == sbt_pkg::SBT_MODULO &&
			count_value == st_ff.channel0_compare_value |=>
			count_value == `SBT_COUNT_RST && st_ff.pending_flags[0];
	endproperty
	a_modulo: assert property (p_modulo) // [RL10]
		else $error("modulo restart wrong");

	property p_suspend;
		st_ff.mode == sbt_pkg::SBT_SUSPEND && !we |=> $stable(count_value);
	endproperty
	a_suspend: assert property (p_suspend) // [RL8]
		else $error("count moved while suspended");

	property p_div128;
		fire && st_ff.psc_sel == 2'h3 |-> st_ff.psc == `SBT_DIV128_M;
	endproperty
	a_div128: assert property (p_div128) // [RL6]
		else $error("divide by 128 fired early");

	property p_psc_free;
		we && sel == sbt_pkg::SBT_R_CTL |=>
			st_ff.psc == 7'($past(st_ff.psc) + {6'h00, $past(tick)});
	endproperty
	a_psc_free: assert property (p_psc_free) // [RL7]
		else $error("prescaler counter disturbed by write");

	sequence s_turn;
		upd && st_ff.mode == sbt_pkg::SBT_UPDOWN && !we &&
			st_ff.dir == sbt_pkg::SBT_DOWN && count_value == 16'h0001;
	endsequence

	property p_turn;
		s_turn ##0 st_ff.compare_sel |=> count_value == `SBT_COUNT_RST &&
			st_ff.pending_flags[1:0] == 2'h3 && st_ff.dir == sbt_pkg::SBT_UP;
	endproperty
	a_turn: assert property (p_turn) // [RL21]
		else $error("turn at zero did not set both flags");

	property p_toggle;
		match_ev && st_ff.compare_action == sbt_pkg::SBT_ACT_TOG |=>
			ch0_out != $past(ch0_out);
	endproperty
	a_toggle: assert property (p_toggle) // [RL13]
		else $error("toggle action missed");

	property p_irq;
		st_ff.pending_flags[1] && st_ff.channel_irq_mask |=>
			cpu_timer_irq_flag;
	endproperty
	a_irq: assert property (p_irq) // [RL20]
		else $error("masked-in flag gave no cpu flag");

	property p_radio_capt;
		!st_ff.compare_sel && st_ff.capture_source_select &&
			st_ff.capture_edge_select != 2'h0 &&
			|(radio_events & st_ff.radio_event_mask) |=>
			st_ff.channel0_compare_value == $past(count_value) &&
			st_ff.pending_flags[1];
	endproperty
	a_radio_capt: assert property (p_radio_capt) // [RL12]
		else $error("radio capture missed");

endmodule // sbt_timer

// File: tb/sbt_timer_tb.sv
// self-checking bench for the sixteen-bit timer core, apb register access
// assumes the design is built with ADDR_W of 12; the bench is the only master
`timescale 1ns/1ps
module sbt_timer_tb;
	// ------------------------------------------------------------------
	// signals and register byte addresses
	// ------------------------------------------------------------------
	localparam logic [11:0] A_LO    = 12'h388;
	localparam logic [11:0] A_SNAP  = 12'h38C;
	localparam logic [11:0] A_CTL   = 12'h390;
	localparam logic [11:0] A_CCTL  = 12'h394;
	localparam logic [11:0] A_CCL   = 12'h368;
	localparam logic [11:0] A_CCH   = 12'h36C;
	localparam logic [11:0] A_RADIO = 12'h3C0;
	localparam logic [7:0]  CC_T [8] = '{8'h44, 8'h4C, 8'h54, 8'h54,
		8'h5C, 8'h5C, 8'h64, 8'h64};
	localparam int          N_T  [8] = '{5, 6, 6, 6, 6, 1, 5, 1};
	localparam logic        O_T  [8] = '{1, 0, 1, 0, 1, 0, 0, 1};
	logic        clock, resetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  pstrb;
	logic        tick, capture_pin, ch1_event, ch2_event;
	logic        ch1_irq_mask, ch2_irq_mask, ch0_out, cpu_timer_irq_flag;
	logic [7:0]  radio_events, rd_v;
	logic [15:0] count_value;
	logic        err_v;
	int          failures, checks_done, i, cnt;

	// device under test, every port by name
	sbt_timer #(.ADDR_W(12)) i_sbt_timer (.clock(clock), .resetn(resetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .tick(tick), .capture_pin(capture_pin),
		.radio_events(radio_events), .ch1_event(ch1_event),
		.ch2_event(ch2_event), .ch1_irq_mask(ch1_irq_mask),
		.ch2_irq_mask(ch2_irq_mask), .count_value(count_value),
		.ch0_out(ch0_out), .cpu_timer_irq_flag(cpu_timer_irq_flag));

	// ------------------------------------------------------------------
	// clock, access tasks and verdict
	// ------------------------------------------------------------------
	// 250 MHz free-running clock
	initial
	begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one apb transfer; an idle edge after it so psel never toggles twice
	task xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= {24'h000000, d};
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1)
			@(posedge clock);
		rd_v    = prdata[7:0];
		err_v   = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask

	task rd(input logic [11:0] a, input logic [7:0] exp, input string what);
		xfer(1'b0, a, 8'h00);
		chk(what, {8'h00, exp}, {8'h00, rd_v});
	endtask

	// tick held high for n sampling edges, then settle time for the count
	task ticks(input int n);
		repeat (n)
		begin
			tick <= 1'b1;
			@(posedge clock);
		end
		tick <= 1'b0;
		repeat (3)
			@(posedge clock);
	endtask

	task close_out;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// watchdog; the free-running wrap alone needs about 66k cycles
	initial
	begin
		repeat (80000)
			@(posedge clock);
		failures++;
		$display("ERROR watchdog expected finish seen hang");
		close_out();
	end

	// ------------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------------
	initial
	begin
		{resetn, psel, penable, pwrite, tick, capture_pin} = 6'h00;
		{ch1_event, ch2_event, ch1_irq_mask, ch2_irq_mask} = 4'h0;
		{paddr, pwdata, radio_events} = 52'h0;
		pstrb = 4'hF;
		repeat (16)
			@(posedge clock);
		resetn <= 1'b1;
		@(posedge clock);
		rd(A_LO, 8'h00, "count low reset");
		rd(A_SNAP, 8'h00, "snapshot reset");
		rd(A_CTL, 8'h00, "control reset");
		rd(A_CCTL, 8'h40, "ch0 control reset");
		rd(12'h3C4, 8'h01, "ovf mask reset");
		xfer(1'b0, 12'h004, 8'h00);
		chk("unmapped error", 16'h0001, {15'h0000, err_v});
		ticks(10);
		chk("suspended count", 16'h0000, count_value);
		$display("test reset finished");
		xfer(1'b1, A_CTL, 8'h01);
		ticks(291);
		rd(A_LO, 8'h23, "live low byte");
		ticks(256);
		rd(A_SNAP, 8'h01, "stale snapshot");
		rd(A_LO, 8'h23, "low byte again");
		rd(A_SNAP, 8'h02, "new snapshot");
		// lane 0 strobe low: the write must be ignored
		pstrb <= 4'hE;
		xfer(1'b1, A_LO, 8'h00);
		pstrb <= 4'hF;
		chk("strobe ignored", 16'h0223, count_value);
		xfer(1'b1, A_LO, 8'hA5);
		chk("count after low write", 16'h0000, count_value);
		ticks(65535);
		chk("terminal count", 16'hFFFF, count_value);
		rd(A_CTL, 8'h01, "no overflow yet");
		ticks(1);
		chk("wrapped count", 16'h0000, count_value);
		rd(A_CTL, 8'h11, "overflow flag");
		chk("irq on overflow", 16'h0001, {15'h0000, cpu_timer_irq_flag});
		xfer(1'b1, A_CTL, 8'h01);
		repeat (2)
			@(posedge clock);
		chk("irq after clear", 16'h0000, {15'h0000, cpu_timer_irq_flag});
		$display("test free running finished");
		// a window of 128 ticks holds whole periods, whatever the phase
		for (i = 0; i < 4; i++)
		begin
			xfer(1'b1, A_CTL, 8'(i * 4 + 1));
			xfer(1'b1, A_LO, 8'h00);
			ticks(128);
			chk("divided count", 16'(128 >> (i == 0 ? 0 : 2 * i + 1)), count_value);
		end
		$display("test prescaler finished");
		ch1_event <= 1'b1;
		ch2_event <= 1'b1;
		@(posedge clock);
		ch1_event <= 1'b0;
		ch2_event <= 1'b0;
		repeat (2)
			@(posedge clock);
		rd(A_CTL, 8'hCD, "channel flags");
		chk("irq masked", 16'h0000, {15'h0000, cpu_timer_irq_flag});
		ch2_irq_mask <= 1'b1;
		repeat (3)
			@(posedge clock);
		chk("irq unmasked", 16'h0001, {15'h0000, cpu_timer_irq_flag});
		xfer(1'b1, A_CTL, 8'hFD);
		rd(A_CTL, 8'hCD, "write one keeps");
		xfer(1'b1, A_CTL, 8'h7D);
		rd(A_CTL, 8'h4D, "write zero clears");
		chk("irq flag gone", 16'h0000, {15'h0000, cpu_timer_irq_flag});
		$display("test flags finished");
		xfer(1'b1, A_CCL, 8'h05);
		xfer(1'b1, A_CCH, 8'h00);
		xfer(1'b1, A_CTL, 8'h02);
		xfer(1'b1, A_LO, 8'h00);
		cnt = 0;
		for (i = 0; i < 8; i++)
		begin
			xfer(1'b1, A_CCTL, CC_T[i]);
			ticks(N_T[i]);
			cnt = (cnt + N_T[i]) % 6;
			chk("modulo count", 16'(cnt), count_value);
			chk("compare output", {15'h0000, O_T[i]}, {15'h0000, ch0_out});
		end
		rd(A_CTL, 8'h32, "modulo flags");
		$display("test modulo compare finished");
		xfer(1'b1, A_CTL, 8'h03);
		xfer(1'b1, A_CCTL, 8'h44);
		ticks(7);
		chk("up down falling", 16'h0003, count_value);
		rd(A_CTL, 8'h03, "no turn yet");
		ticks(3);
		chk("up down at zero", 16'h0000, count_value);
		rd(A_CTL, 8'h33, "turn flags");
		$display("test up down finished");
		for (i = 0; i < 4; i++)
		begin
			xfer(1'b1, A_CTL, 8'h00);
			xfer(1'b1, A_CCTL, 8'(8'h40 + i));
			capture_pin <= 1'b1;
			repeat (8)
				@(posedge clock);
			rd(A_CTL, 8'(i % 2) << 5, "rising capture");
			xfer(1'b1, A_CTL, 8'h00);
			capture_pin <= 1'b0;
			repeat (8)
				@(posedge clock);
			rd(A_CTL, 8'(i / 2) << 5, "falling capture");
		end
		rd(A_CCL, 8'h00, "captured count");
		xfer(1'b1, A_RADIO, 8'h01);
		xfer(1'b1, A_CCTL, 8'hC1);
		xfer(1'b1, A_CTL, 8'h00);
		for (i = 0; i < 2; i++)
		begin
			radio_events <= 8'(2 >> i);
			@(posedge clock);
			radio_events <= 8'h00;
			repeat (4)
				@(posedge clock);
			rd(A_CTL, 8'(i) << 5, "radio capture");
		end
		$display("test capture finished");
		close_out();
	end
endmodule // sbt_timer_tb
